// *** hdl/sbis_pkg.sv ***
// Package for the serial break interrupt scan block: constants and carrier types
package sbis_pkg;
  localparam logic [7:0] GLOBAL_AUTH_CHAR = 8'h1b;
  localparam logic [1:0] GROUP_PREFIX     = 2'h3;
  localparam logic [1:0] ACK_PREFIX       = 2'h2;
  localparam int         ADDR_W           = 6;
  localparam int         CLK_MHZ          = 250;
  // Times in their own units
  localparam int         BREAK_US         = 500;
  localparam int         START_MAX_US     = 20;
  localparam int         RELEASE_MAX_US   = 30;
  localparam int         AUTH_MAX_US_4800 = 3000;
  // Cycle counts derived from the clock rate
  localparam int         BREAK_CYCLES     = BREAK_US * CLK_MHZ;
  localparam int         START_CYCLES     = START_MAX_US * CLK_MHZ;
  localparam int         RELEASE_CYCLES   = RELEASE_MAX_US * CLK_MHZ;
  localparam int         AUTH_CYCLES      = AUTH_MAX_US_4800 * CLK_MHZ;
  localparam int         CNT_W            = 20;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbis_char_t;

  typedef struct packed {
    logic                valid;
    logic [ADDR_W-1:0]   addr;
  } sbis_status_rd_t;
endpackage

// *** hdl/sbis_core.sv ***
// Break signalling engine for the serial interrupt scan protocol
`timescale 1ns/10ps
module sbis_core #(
  parameter int BREAK_LEN = sbis_pkg::BREAK_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic [sbis_pkg::ADDR_W-1:0] module_addr,
  input  wire sbis_pkg::sbis_char_t        rx_char,
  input  wire sbis_pkg::sbis_status_rd_t   alt_status_read_command,
  input  wire logic                        irq_event,
  input  wire logic                        uart_txd,
  output logic                             txd_out,
  output logic                             txd_oe_b,
  output logic                             irq_pending,
  output logic                             break_active
);
  typedef enum logic [1:0] {
    SBIS_IDLE  = 2'b01,
    SBIS_BREAK = 2'b10
  } sbis_state_t;

  sbis_state_t                 state_reg, state_next;
  logic                        pend_reg, pend_next;
  logic                        latch_reg, latch_next;
  logic                        proto_reg, proto_next;
  logic [sbis_pkg::CNT_W-1:0]  cnt_reg, cnt_next;

  logic is_global;
  logic is_group;
  logic is_ack;
  logic ack_me;
  logic group_hit;
  logic fire;

  logic clr_req;

  // Every character of this protocol is decoded in a single cycle, so the
  // answer to a character never depends on the character after it. The
  // host may therefore send scans back to back; the only spacing it must
  // keep is the break length plus the release time between characters.

  // Address qualification for group scans
  function automatic logic addr_match(
    input logic [sbis_pkg::ADDR_W-1:0] a,
    input logic [sbis_pkg::ADDR_W-1:0] m
  );
    addr_match = ((a & m) == m);
  endfunction

  // Two top bits tell scans from acknowledges
  function automatic logic prefix_is(
    input logic [7:0] c,
    input logic [1:0] p
  );
    prefix_is = (c[7:6] == p);
  endfunction

  // A character only counts on its valid strobe
  always_comb begin
    is_global = rx_char.valid && (rx_char.data == sbis_pkg::GLOBAL_AUTH_CHAR);
    is_group  = rx_char.valid && prefix_is(rx_char.data, sbis_pkg::GROUP_PREFIX);
    is_ack    = rx_char.valid && prefix_is(rx_char.data, sbis_pkg::ACK_PREFIX);
    ack_me    = is_ack && (rx_char.data[5:0] == module_addr);
    group_hit = is_group && addr_match(module_addr, rx_char.data[5:0]);
  end

  // Request group
  // The pending flag follows the fault sources; the latched copy is a
  // snapshot taken only at a global authorization. That snapshot freezes
  // the set of modules allowed to answer the scans that follow, which is
  // what lets the host run its dichotomic search without the answers
  // shifting under it.
  always_comb begin
    pend_next  = pend_reg;
    latch_next = latch_reg;
    clr_req    = ack_me || alt_status_read_command.valid;
    if (clr_req) begin
      pend_next  = 1'b0;
      latch_next = 1'b0;
    end
    // Set wins over clear so an event is never lost
    if (irq_event) begin
      pend_next = 1'b1;
    end
    if (is_global) begin
      latch_next = pend_reg || irq_event;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg  <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      latch_reg <= latch_next;
    end
  end

  // Protocol group
  // Any foreign character or a status read drops the module back to
  // normal dialogue; the next scan or acknowledge draws no break but re-arms
  // the module for the one after it. A status read also clears the request,
  // so the host loses the fault itself as well as the frozen snapshot.
  always_comb begin
    proto_next = proto_reg;
    if (rx_char.valid) begin
      proto_next = is_global || is_group || is_ack;
    end
    if (alt_status_read_command.valid) begin
      proto_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      proto_reg <= 1'b0;
    end else begin
      proto_reg <= proto_next;
    end
  end

  // Break request, at most one per character
  always_comb begin
    fire = 1'b0;
    if (is_global) begin
      fire = pend_reg || irq_event;
    end
    // only requests latched at last global
    if (group_hit && latch_reg && proto_reg) begin
      fire = 1'b1;
    end
    if (is_ack && !ack_me && latch_reg && proto_reg) begin
      fire = 1'b1;
    end
  end

  // Break group
  // The break is timed by a plain cycle counter, so its length scales
  // with the clock; BREAK_LEN must be changed with any other clock rate.
  // A character that arrives while a break runs is decoded for the flags
  // but cannot stretch or restart the break: the host is expected to wait
  // out the break before its next scan, and a second break glued to the
  // first would look like one long break on the link.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      SBIS_IDLE: begin
        // break starts next cycle; one per character
        if (fire) begin
          state_next = SBIS_BREAK;
          cnt_next   = '0;
        end
      end
      SBIS_BREAK: begin
        if (cnt_reg == sbis_pkg::CNT_W'(BREAK_LEN - 1)) begin
          state_next = SBIS_IDLE;
          cnt_next   = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SBIS_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Line drive
  // The transmitter stays push-pull; merging the lines of several modules
  // happens outside the block, so the enable is held on permanently.
  // Outside a break the normal serial data passes straight through, which
  // keeps the ordinary dialogue untouched by this block.
  // break drives line low; release is immediate on exit
  always_comb begin
    break_active = (state_reg == SBIS_BREAK);
    txd_out      = break_active ? 1'b0 : uart_txd;
    txd_oe_b     = 1'b0;
    irq_pending  = pend_reg;
  end
endmodule // sbis_core

// *** verif/sbis_core_sva.sv ***
// Assertion checker for the break scan engine
`timescale 1ns/10ps
module sbis_core_sva #(parameter int BREAK_LEN = 20) (
  input wire logic                      mclk,
  input wire logic                      rst_b,
  input wire logic [5:0]                module_addr,
  input wire sbis_pkg::sbis_char_t      rx_char,
  input wire sbis_pkg::sbis_status_rd_t alt_status_read_command,
  input wire logic                      irq_event,
  input wire logic                      uart_txd,
  input wire logic                      txd_out,
  input wire logic                      irq_pending,
  input wire logic                      break_active
);
  int         cnt_reg, cnt_next;
  wire logic  v = rx_char.valid;
  wire [7:0]  d = rx_char.data;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Counts high cycles of the current break
  always_comb cnt_next = break_active ? cnt_reg + 1 : 0;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) cnt_reg <= 0;
    else cnt_reg <= cnt_next;
  a_glob_brk: assert property (v && d == 8'h1b && irq_pending && !break_active |=> break_active)
    else $error("global");
  a_grp_block: assert property (v && d[7:6] == 2'h3 && (d[5:0] & ~module_addr) != 6'h0
    |=> !$rose(break_active)) else $error("group");
  a_brk_low: assert property (break_active |-> !txd_out) else $error("low");
  a_tx_pass: assert property (!break_active |-> txd_out == uart_txd) else $error("pass");
  a_brk_len: assert property ($fell(break_active) |-> cnt_reg == BREAK_LEN) else $error("len");
  a_ack_clr: assert property (v && d == {2'h2, module_addr} && !irq_event |=> !irq_pending)
    else $error("ack");
  a_stat_ack: assert property (alt_status_read_command.valid && !irq_event |=> !irq_pending)
    else $error("status");
  a_brk_cause: assert property ($rose(break_active) |-> $past(v)) else $error("cause");
  c_brk: cover property ($rose(break_active));
  c_ack: cover property (v && d == {2'h2, module_addr});
  c_stat: cover property (alt_status_read_command.valid);
endmodule // sbis_core_sva

// *** verif/sbis_host.sv ***
// Host model: sends single protocol characters on the shared link
`timescale 1ns/10ps
module sbis_host (
  input  wire logic           mclk,
  output sbis_pkg::sbis_char_t rx_char
);
  initial rx_char = '0;
  task automatic send(input logic [7:0] c);
    @(negedge mclk) rx_char = {1'b1, c};
    @(negedge mclk) rx_char = '0;
  endtask
endmodule // sbis_host

// *** verif/tb_top.sv ***
// Self-checking bench for the break scan engine
`timescale 1ns/10ps
module tb_top;
  localparam int BL = 20;
  logic                      mclk = 0, rst_b = 0, irq_event = 0, uart_txd = 0, seen;
  logic                      txd_out, irq_pending, break_active;
  int                        err_total = 0, checked = 0;
  sbis_pkg::sbis_char_t      rx_char;
  sbis_pkg::sbis_status_rd_t stat = '0;
  // Row: request pulse, break expected, character
  // Scans add mask bits; a silent scan means no match or no latched request
  logic [9:0]                rows [9] = '{10'h31b, 10'h1c1, 10'h0c3, 10'h1ed, 10'h189,
                                          10'h0ad, 10'h0c1, 10'h2c1, 10'h11b};
  sbis_host host (.mclk(mclk), .rx_char(rx_char));
  sbis_core #(.BREAK_LEN(BL)) dut (.mclk(mclk), .rst_b(rst_b), .module_addr(6'h2d),
    .rx_char(rx_char), .alt_status_read_command(stat), .irq_event(irq_event),
    .uart_txd(uart_txd), .txd_out(txd_out), .txd_oe_b(), .irq_pending(irq_pending),
    .break_active(break_active));
  initial forever #2 mclk = ~mclk;
  always @(negedge mclk) uart_txd <= ~uart_txd;
  task end_of_test;
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task pulse;
    @(negedge mclk) irq_event = 1;
    @(negedge mclk) irq_event = 0;
  endtask
  // Break must show within the window of BL + 4 cycles; its end is not checked
  // Host waits out each answer before the next scan
  task op(input logic [7:0] c, input logic e);
    seen = 0;
    host.send(c);
    repeat (BL + 4) @(negedge mclk) seen |= break_active;
    chk("break", e, seen);
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_b = 1;
    foreach (rows[i]) begin
      if (rows[i][9]) pulse();
      op(rows[i][7:0], rows[i][8]);
    end
    @(negedge mclk) stat = {1'b1, 6'h2d};
    @(negedge mclk) stat = '0;
    chk("pending", 0, irq_pending);
    pulse();
    host.send(8'h1b);
    repeat (3) @(negedge mclk);
    rst_b = 0;
    #1;
    chk("rst brk", 0, break_active);
    chk("rst pend", 0, irq_pending);
    end_of_test();
  end
  // Whole run needs about 255 cycles
  initial begin
    #8000;
    err_total++;
    end_of_test();
  end
endmodule // tb_top
bind sbis_core sbis_core_sva #(.BREAK_LEN(BREAK_LEN)) sva (.mclk(mclk), .rst_b(rst_b),
  .module_addr(module_addr), .rx_char(rx_char), .irq_event(irq_event),
  .alt_status_read_command(alt_status_read_command), .uart_txd(uart_txd),
  .txd_out(txd_out), .irq_pending(irq_pending), .break_active(break_active));
